// >>> core/lo_path_cfg.sv
// Serial word capture and LO path, VCO and divider configuration registers
`timescale 1ns/100ps
`include "lo_cfg_consts.svh"
module lo_path_cfg import lo_cfg_pkg::*; (
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    input  wire logic       SER_CLK,
    input  wire logic       SER_DATA,
    input  wire logic       SER_LATCH,
    output logic            LOW_POWER_MIXER,
    output logic            LO_PINS_AS_INPUT,
    output logic            LO_DRIVER_EN,
    output logic            BAND_SOURCE_SELECT,
    output logic      [5:0] VCO_BAND_VALUE,
    output logic      [4:0] VCO_AMPLITUDE,
    output logic            VCO_DISABLE,
    output logic            VCO_LDO_DISABLE,
    output logic            CP_ENABLE,
    output logic      [1:0] STAGE1_CODE,
    output logic      [1:0] STAGE2_CODE,
    output logic      [1:0] OUT_DIV_CODE,
    output logic      [6:0] LO_DIV_RATIO,
    output logic      [3:0] OUT_DIV_RATIO,
    output logic            CAL_START
);
    logic [2:0]  lvl;
    logic [2:0]  rise;
    logic [23:0] shift_reg;
    logic [4:0]  cnt_reg;
    logic [23:0] word_reg;
    logic        stb_reg;
    logic [2:0]  sel;
    lo_path_t    lp_reg;
    vco_ctrl_t   vc_reg;
    lo_div_t     ld_reg;
    logic [6:0]  lo_ratio_reg;
    logic [3:0]  out_ratio_reg;
    logic        cal_reg;
    logic        vco_written_reg;

    // Pins come from the host's domain
    pin_sync #(.WIDTH(3)) u_sync (
        .CLOCK  (CLOCK),
        .RST_N  (RST_N),
        .PIN_IN ({SER_CLK, SER_DATA, SER_LATCH}),
        .LEVEL  (lvl),
        .RISE   (rise)
    );

    function automatic logic [2:0] stage1_ratio(input logic [1:0] c);
        return {1'b0, c} + 3'h2;
    endfunction

    function automatic logic [3:0] stage2_ratio(input logic [1:0] c);
        unique case (c)
            2'h1: return 4'h2;
            2'h2: return 4'h4;
            2'h3: return 4'h8;
            2'h0: return 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] out_ratio(input logic [1:0] c);
        unique case (c)
            2'h3: return 4'h8;
            2'h2: return 4'h6;
            2'h1: return 4'h4;
            2'h0: return 4'h0;
        endcase
    endfunction

    assign sel = word_reg[2:0];

    // Bit counter saturates so overlong words are rejected
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            shift_reg <= 24'h00_0000;
            cnt_reg   <= 5'h00;
        end
        else if (rise[0])
            cnt_reg <= 5'h00;
        else if (rise[2])
        begin
            shift_reg <= {shift_reg[22:0], lvl[1]};
            if (cnt_reg != 5'h19)
                cnt_reg <= cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            word_reg <= 24'h00_0000;
            stb_reg  <= 1'b0;
        end
        else
        begin
            stb_reg <= rise[0] && (cnt_reg == 5'(`WORD_BITS));
            if (rise[0])
                word_reg <= shift_reg;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            lp_reg <= `RST_LO_PATH;
        else if (stb_reg && sel == `SEL_LO_PATH)
        begin
            lp_reg.low_power            <= word_reg[`LP_LOW_POWER];
            lp_reg.external_lo_bit      <= word_reg[`LP_EXT_LO];
            lp_reg.lo_output_driver_bit <= word_reg[`LP_DRIVER];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            vc_reg.band_source_select <= 1'b0;
            vc_reg.band_value         <= `RST_BAND;
            vc_reg.amplitude          <= `RST_VCO_AMP;
            vc_reg.cp_enable          <= 1'b1;
            vc_reg.vco_disable        <= 1'b0;
            vc_reg.ldo_disable        <= 1'b0;
            vco_written_reg           <= 1'b0;
        end
        else if (stb_reg && sel == `SEL_VCO_CTRL)
        begin
            vc_reg.band_source_select <= word_reg[`VC_BAND_SRC];
            vc_reg.band_value <= word_reg[`VC_BAND_MSB:`VC_BAND_LSB];
            vc_reg.amplitude  <= word_reg[`VC_AMP_MSB:`VC_AMP_LSB];
            vc_reg.cp_enable   <= word_reg[`VC_CP_EN];
            vc_reg.vco_disable <= word_reg[`VC_VCO_DIS];
            vc_reg.ldo_disable <= word_reg[`VC_LDO_DIS];
            vco_written_reg    <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ld_reg        <= {`RST_ST1, `RST_ST2, `RST_OUT};
            lo_ratio_reg  <= `RST_LO_RATIO;
            out_ratio_reg <= `RST_OUT_RATIO;
        end
        else if (stb_reg && sel == `SEL_LO_DIV)
        begin
            ld_reg.stage1_code <= word_reg[`LD_ST1_MSB:`LD_ST1_LSB];
            ld_reg.stage2_code <= word_reg[`LD_ST2_MSB:`LD_ST2_LSB];
            ld_reg.out_code    <= word_reg[`LD_OUT_MSB:`LD_OUT_LSB];
            // Quadrature divide-by-2 closes the cascade
            lo_ratio_reg <= 7'({4'h0, stage1_ratio(
                word_reg[`LD_ST1_MSB:`LD_ST1_LSB])}
                * stage2_ratio(word_reg[`LD_ST2_MSB:`LD_ST2_LSB]) * 7'h2);
            out_ratio_reg <= out_ratio(word_reg[`LD_OUT_MSB:`LD_OUT_LSB]);
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            cal_reg <= 1'b0;
        else
            cal_reg <= stb_reg && (sel <= `SEL_LAST_FREQ);
    end

    assign LOW_POWER_MIXER    = lp_reg.low_power;
    assign LO_PINS_AS_INPUT   = lp_reg.external_lo_bit;
    assign LO_DRIVER_EN       = lp_reg.lo_output_driver_bit;
    assign BAND_SOURCE_SELECT = vc_reg.band_source_select;
    assign VCO_BAND_VALUE     = vc_reg.band_value;
    assign VCO_AMPLITUDE      = vc_reg.amplitude;
    assign VCO_DISABLE        = vc_reg.vco_disable;
    assign VCO_LDO_DISABLE    = vc_reg.ldo_disable;
    assign CP_ENABLE          = vc_reg.cp_enable;
    assign STAGE1_CODE        = ld_reg.stage1_code;
    assign STAGE2_CODE        = ld_reg.stage2_code;
    assign OUT_DIV_CODE       = ld_reg.out_code;
    assign LO_DIV_RATIO       = lo_ratio_reg;
    assign OUT_DIV_RATIO      = out_ratio_reg;
    assign CAL_START          = cal_reg;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_write(logic [2:0] code);
        stb_reg && sel == code;
    endsequence

    a_word_strobe: assert property (
        rise[0] && cnt_reg == 5'h18 |=> stb_reg)
        else $error("Complete word not strobed");
    a_short_word: assert property (
        rise[0] && cnt_reg != 5'h18 |=> !stb_reg)
        else $error("Incomplete word strobed");
    a_low_power: assert property (
        s_write(3'h5) |=> LOW_POWER_MIXER == $past(word_reg[5]))
        else $error("Low power bit not applied");
    a_lo_driver: assert property (
        s_write(3'h5) |=> LO_DRIVER_EN == $past(word_reg[3])
            && LO_PINS_AS_INPUT == $past(word_reg[4]))
        else $error("LO pin settings not applied");
    a_vco_load: assert property (
        s_write(3'h6) |=> VCO_AMPLITUDE == $past(word_reg[15:11])
            && CP_ENABLE == $past(word_reg[16]))
        else $error("VCO register not loaded");
    a_vco_hold: assert property (
        !(stb_reg && sel == 3'h6)
            |=> $stable(VCO_AMPLITUDE) && $stable(VCO_DISABLE))
        else $error("VCO register changed without write");
    a_amp_default: assert property (
        !vco_written_reg |-> VCO_AMPLITUDE == 5'h18 && CP_ENABLE)
        else $error("VCO defaults wrong");
    a_ratio_top: assert property (
        s_write(3'h7) ##0 (word_reg[9:6] == 4'hf)
            |=> LO_DIV_RATIO == 7'h50)
        else $error("Divide-by-80 not decoded");
    a_ratio_low: assert property (
        s_write(3'h7) ##0 (word_reg[9:6] == 4'h1)
            |=> LO_DIV_RATIO == 7'h08)
        else $error("Divide-by-8 not decoded");
    a_out_ratio: assert property (
        s_write(3'h7) ##0 (word_reg[5:4] == 2'h2)
            |=> OUT_DIV_RATIO == 4'h6)
        else $error("Output divide-by-6 not decoded");
    a_cal_pulse: assert property (
        stb_reg && sel <= 3'h2 |=> CAL_START ##1 !CAL_START || stb_reg)
        else $error("Calibration pulse missing");
    a_cal_quiet: assert property (
        stb_reg && sel > 3'h2 |=> !CAL_START)
        else $error("Calibration started by other register");
endmodule // lo_path_cfg

// >>> shared/lo_cfg_consts.svh
// Offsets, field positions, reset values and counts of the LO configuration
`ifndef LO_CFG_CONSTS_SVH
`define LO_CFG_CONSTS_SVH
`define WORD_BITS        24
`define SEL_LO_PATH      3'h5
`define SEL_VCO_CTRL     3'h6
`define SEL_LO_DIV       3'h7
`define SEL_LAST_FREQ    3'h2
`define LP_LOW_POWER     5
`define LP_EXT_LO        4
`define LP_DRIVER        3
`define VC_BAND_LSB      4
`define VC_BAND_MSB      9
`define VC_BAND_SRC      10
`define VC_AMP_LSB       11
`define VC_AMP_MSB       15
`define VC_CP_EN         16
`define VC_VCO_DIS       17
`define VC_LDO_DIS       18
`define LD_OUT_LSB       4
`define LD_OUT_MSB       5
`define LD_ST2_LSB       6
`define LD_ST2_MSB       7
`define LD_ST1_LSB       8
`define LD_ST1_MSB       9
`define RST_LO_PATH      3'h0
`define RST_VCO_AMP      5'h18
`define RST_BAND         6'h00
`define RST_ST1          2'h3
`define RST_ST2          2'h1
`define RST_OUT          2'h3
`define RST_LO_RATIO     7'h14
`define RST_OUT_RATIO    4'h8
`endif

// >>> shared/lo_cfg_pkg.sv
// Types carried between the serial front end and the configuration outputs
package lo_cfg_pkg;
    typedef struct packed {
        logic low_power;
        logic external_lo_bit;
        logic lo_output_driver_bit;
    } lo_path_t;
    typedef struct packed {
        logic       band_source_select;
        logic [5:0] band_value;
        logic [4:0] amplitude;
        logic       cp_enable;
        logic       vco_disable;
        logic       ldo_disable;
    } vco_ctrl_t;
    typedef struct packed {
        logic [1:0] stage1_code;
        logic [1:0] stage2_code;
        logic [1:0] out_code;
    } lo_div_t;
endpackage

// >>> core/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             CLOCK,
    input  wire logic             RST_N,
    input  wire logic [WIDTH-1:0] PIN_IN,
    output logic      [WIDTH-1:0] LEVEL,
    output logic      [WIDTH-1:0] RISE
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            logic rise_reg;
            always_ff @(posedge CLOCK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= PIN_IN[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            // A change counts only once stages two and three agree
            always_ff @(posedge CLOCK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    lvl_reg  <= 1'b0;
                    rise_reg <= 1'b0;
                end
                else
                begin
                    rise_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg;
                end
            end
            assign LEVEL[i] = lvl_reg;
            assign RISE[i]  = rise_reg;
        end
    endgenerate
endmodule // pin_sync

// >>> verif/ser_host.sv
// Serial host model that shifts configuration words into the block
`timescale 1ns/100ps
module ser_host (
    input  wire logic CLOCK,
    output logic      SER_CLK,
    output logic      SER_DATA,
    output logic      SER_LATCH
);
    initial
    begin
        SER_CLK   = 1'b0;
        SER_DATA  = 1'b0;
        SER_LATCH = 1'b1;
    end

    // Four cycles a level, so the pin filter always agrees on it
    task automatic hold();
        repeat (4) @(posedge CLOCK);
        #1;
    endtask

    task automatic send(input logic [31:0] w, input int n);
        SER_LATCH = 1'b0;
        hold();
        for (int b = n - 1; b >= 0; b--)
        begin
            SER_DATA = w[b];
            hold();
            SER_CLK = 1'b1;
            hold();
            SER_CLK = 1'b0;
        end
        hold();
        SER_LATCH = 1'b1;
        // Released line has no pull, so a stale bit must not look valid
        SER_DATA = ~SER_DATA;
        hold();
    endtask
endmodule // ser_host

// >>> verif/tb_top.sv
// Self-checking bench for the LO path configuration bank
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, e, g)
module tb_top;
    import lo_cfg_pkg::*;
    logic       CLOCK;
    logic       RST_N;
    logic       sck;
    logic       sda;
    logic       sle;
    logic       lp;
    logic       lin;
    logic       drv;
    logic       bsrc;
    logic [5:0] band;
    logic [4:0] amp;
    logic       vdis;
    logic       ldis;
    logic       cp;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] oc;
    logic [6:0] ratio;
    logic [3:0] oratio;
    logic       cal;
    lo_path_t   lp_seen;
    vco_ctrl_t  vco_seen;
    lo_div_t    div_seen;
    int         fail_count = 0;
    int         compares = 0;
    int         cal_seen = 0;

    assign lp_seen  = {lp, lin, drv};
    assign vco_seen = {bsrc, band, amp, cp, vdis, ldis};
    assign div_seen = {s1, s2, oc};

    ser_host u_ser_host (
        .CLOCK     (CLOCK),
        .SER_CLK   (sck),
        .SER_DATA  (sda),
        .SER_LATCH (sle)
    );

    lo_path_cfg u_lo_path_cfg (
        .CLOCK              (CLOCK),
        .RST_N              (RST_N),
        .SER_CLK            (sck),
        .SER_DATA           (sda),
        .SER_LATCH          (sle),
        .LOW_POWER_MIXER    (lp),
        .LO_PINS_AS_INPUT   (lin),
        .LO_DRIVER_EN       (drv),
        .BAND_SOURCE_SELECT (bsrc),
        .VCO_BAND_VALUE     (band),
        .VCO_AMPLITUDE      (amp),
        .VCO_DISABLE        (vdis),
        .VCO_LDO_DISABLE    (ldis),
        .CP_ENABLE          (cp),
        .STAGE1_CODE        (s1),
        .STAGE2_CODE        (s2),
        .OUT_DIV_CODE       (oc),
        .LO_DIV_RATIO       (ratio),
        .OUT_DIV_RATIO      (oratio),
        .CAL_START          (cal)
    );

    initial
    begin
        CLOCK = 1'b0;
    end
    always #5 CLOCK = ~CLOCK;

    always @(posedge CLOCK)
    begin
        if (cal === 1'b1)
            cal_seen++;
    end

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Outputs settle a few cycles after the latch pin rises
    task automatic wr(input logic [23:0] w);
        u_ser_host.send({8'h00, w}, 24);
        repeat (12) @(posedge CLOCK);
        #1;
    endtask

    task automatic t_reset();
        `CHK("lo path", 3'h0, lp_seen);
        `CHK("vco", 15'h00C4, vco_seen);
        `CHK("div codes", 6'h37, div_seen);
        `CHK("lo ratio", 7'h14, ratio);
        `CHK("out ratio", 4'h8, oratio);
        $display("test reset done");
    endtask

    task automatic t_lo();
        // Code two is the external LO setup: driver off, input on
        for (int k = 0; k < 8; k++)
        begin
            wr({18'h0_0000, k[2:0], 3'h5});
            `CHK("lo path", k[2:0], lp_seen);
        end
        `CHK("vco kept", 15'h00C4, vco_seen);
        $display("test lo path done");
    endtask

    task automatic t_vco();
        wr({5'h00, 3'h6, 5'h1F, 1'b1, 6'h2A, 4'h6});
        `CHK("vco", {1'b1, 6'h2A, 5'h1F, 3'h3}, vco_seen);
        wr({5'h00, 3'h1, 5'h00, 1'b0, 6'h15, 4'h6});
        `CHK("vco", {1'b0, 6'h15, 5'h00, 3'h4}, vco_seen);
        `CHK("div kept", 6'h37, div_seen);
        $display("test vco done");
    endtask

    task automatic t_div();
        logic [6:0] er;
        logic [3:0] eo;
        for (int i = 0; i < 4; i++)
            for (int j = 1; j < 4; j++)
            begin
                if (i == 0 && j != 1)
                    continue;
                er = 7'((i + 2) * (1 << j) * 2);
                eo = 4'(j == 3 ? 8 : (j == 2 ? 6 : 4));
                wr({14'h0000, i[1:0], j[1:0], j[1:0], 4'h7});
                `CHK("div codes", {i[1:0], j[1:0], j[1:0]}, div_seen);
                `CHK("lo ratio", er, ratio);
                `CHK("out ratio", eo, oratio);
            end
        $display("test divider done");
    endtask

    task automatic t_order();
        int c0;
        for (int r = 0; r < 2; r++)
        begin
            c0 = cal_seen;
            wr(24'h00_0377);
            wr(24'h01_C006);
            wr(24'h00_0005);
            wr(24'hFF_FFFC);
            wr(24'hFF_FFFB);
            wr(24'h00_0002);
            wr(24'h00_0001);
            wr(24'h00_0000);
            `CHK("cal pulses", 3, cal_seen - c0);
            `CHK("lo path", 3'h0, lp_seen);
            `CHK("vco", 15'h00C4, vco_seen);
            `CHK("div codes", 6'h37, div_seen);
        end
        $display("test order done");
    endtask

    task automatic t_frame();
        int c0;
        c0 = cal_seen;
        u_ser_host.send(32'h0000_003D, 23);
        u_ser_host.send(32'h0000_003D, 25);
        u_ser_host.send(32'h0000_0000, 23);
        repeat (12) @(posedge CLOCK);
        #1;
        `CHK("lo path", 3'h0, lp_seen);
        `CHK("cal pulses", 0, cal_seen - c0);
        $display("test frame length done");
    endtask

    initial
    begin
        RST_N = 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        RST_N = 1'b1;
        @(posedge CLOCK);
        #1;
        t_reset();
        t_lo();
        t_vco();
        t_div();
        t_order();
        t_frame();
        final_report();
    end

    // About 8400 cycles of traffic; over twice that means a hang
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        fail_count++;
        $display("watchdog expired");
        final_report();
    end
endmodule // tb_top
